// [core/serial_unit_consts.vh]
// Constants shared by the asynchronous serial transceiver design files.
`ifndef SERIAL_UNIT_CONSTS_VH
`define SERIAL_UNIT_CONSTS_VH

// Register addresses on the plain register port.
`define ADDR_TX_CTRL     4'h0
`define ADDR_RX_CTRL     4'h1
`define ADDR_BAUD_CTRL   4'h2
`define ADDR_BAUD_LOW    4'h3
`define ADDR_BAUD_HIGH   4'h4
`define ADDR_TX_DATA     4'h5
`define ADDR_RX_DATA     4'h6
`define ADDR_FLAGS       4'h7

// Transmit control register fields.
`define TXC_ENABLE       0
`define TXC_NINE         1
`define TXC_POLARITY     2
`define TXC_NINTH_BIT    3
`define TXC_SHIFT_EMPTY  4
`define TXC_BUF_EMPTY    5

// Receive control register fields.
`define RXC_PORT_ENABLE  0
`define RXC_CONT_RECEIVE 1
`define RXC_NINE         2
`define RXC_ADDR_DETECT  3
`define RXC_MODE_SELECT  4
`define RXC_FRAMING      5
`define RXC_OVERRUN      6
`define RXC_NINTH_BIT    7

// Baud control and flag register fields.
`define BAUD_WIDE        0
`define FLAG_TX          0
`define FLAG_RX          1

// Reset values.
`define BAUD_LOW_RESET   8'h00
`define BAUD_HIGH_RESET  8'h00
`define BYTE_ZERO        8'h00

// Timing in oversampling ticks, sixteen ticks per bit.
`define TICKS_LAST       4'hf
`define TICKS_HALF       4'h7
`define TICK_ZERO        4'h0

// Transmit frame lengths in bits, start and stop bits included; receive lengths count data bits only.
`define TX_FRAME_EIGHT   4'ha
`define TX_FRAME_NINE    4'hb
`define RX_DATA_EIGHT    4'h8
`define RX_DATA_NINE     4'h9

// Receive buffer entry: framing error, ninth bit, eight data bits.
`define FIFO_WIDTH       10
`define FIFO_DEPTH       2
`define ENTRY_FRAMING_ERROR_STATUS       9
`define ENTRY_NINTH      8

`endif

// [core/baud_tick_gen.v]
// Shared baud generator producing one tick per sixteenth of a bit period.
`default_nettype none
`include "serial_unit_consts.vh"

module baud_tick_gen (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        wide_mode,
	input  wire [15:0] period,
	input  wire        restart,
	output reg         tick
);

	reg [15:0] count;
	wire [15:0] reload;

	// In narrow mode only the low byte sets the period.
	assign reload = wide_mode ? period : {8'h00, period[7:0]};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else if (restart) begin
			count <= reload;
			tick  <= 1'b0;
		end else if (count == 16'h0000) begin
			count <= reload;
			tick  <= 1'b1;
		end else begin
			count <= count - 16'h0001;
			tick  <= 1'b0;
		end
	end

endmodule // baud_tick_gen

`default_nettype wire

// [core/receive_fifo.v]
// Two-entry receive buffer holding data, ninth bit and framing error.
`default_nettype none
`include "serial_unit_consts.vh"

module receive_fifo (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire                   flush,
	input  wire                   push,
	input  wire [`FIFO_WIDTH-1:0] push_data,
	input  wire                   pop,
	output wire [`FIFO_WIDTH-1:0] head,
	output wire                   empty,
	output wire                   full
);

	reg [`FIFO_WIDTH-1:0] mem [0:`FIFO_DEPTH-1];
	reg                   wr_ptr;
	reg                   rd_ptr;
	reg [1:0]             count;
	wire                  do_push;
	wire                  do_pop;

	assign empty   = (count == 2'd0);
	assign full    = (count == 2'd2);
	assign head    = mem[rd_ptr];
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;

	always @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'd0;
		end else if (flush) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'd0;
		end else begin
			if (do_push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (do_pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (do_push && !do_pop) begin
				count <= count + 2'd1;
			end else if (do_pop && !do_push) begin
				count <= count - 2'd1;
			end
		end
	end

endmodule // receive_fifo

`default_nettype wire

// [core/async_serial_transceiver.v]
// Asynchronous serial transmitter and receiver with its register port.
//
// Chosen here: the register offsets and the plain strobed port.
`default_nettype none
`include "serial_unit_consts.vh"

module async_serial_transceiver (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [3:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	input  wire       rx_line,
	output wire       tx_line,
	output wire       tx_oe
);

	////////////////////////////////////////////////////////////////////////////
	localparam RX_IDLE  = 2'b00;
	localparam RX_START = 2'b01;
	localparam RX_DATA  = 2'b10;
	localparam RX_STOP  = 2'b11;

	function majority;
		input [2:0] s;
		begin
			majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		end
	endfunction

	// Control bits written by software.
	reg        transmit_enable_bit;
	reg        nine_bit_transmit_select;
	reg        output_polarity_bit;
	reg        transmit_ninth_bit;
	reg        port_enable_bit;
	reg        continuous_receive_enable;
	reg        nine_bit_receive_select;
	reg        address_detect_enable;
	reg        mode_select_bit;
	reg        baud_wide;
	reg  [7:0] baud_low;
	reg  [7:0] baud_high;

	// Transmit state.
	reg  [7:0]  transmit_buffer;
	reg         buffer_ninth;
	reg         buffer_full;
	reg  [10:0] transmit_shift_register;
	reg  [3:0]  tx_bits_left;
	reg  [3:0]  tx_ticks;
	reg         tx_busy;
	reg         transmit_buffer_empty_flag;

	// Receive state.
	reg  [1:0] rx_state;
	reg  [3:0] rx_ticks;
	reg  [3:0] rx_bits;
	reg  [8:0] receive_shift_register;
	reg  [2:0] rx_samples;
	reg        rx_prev;
	reg        overrun_error_status;

	wire       tick;
	wire       tx_active;
	wire       rx_active;
	wire       baud_restart;
	wire       tx_write;
	wire       rx_pop;
	wire       tx_load;
	wire       rx_vote;
	wire       rx_push;
	wire       rx_keep;
	wire [7:0] rx_char;
	wire       rx_ninth;
	wire [`FIFO_WIDTH-1:0] fifo_head;
	wire       fifo_empty;
	wire       fifo_full;
	wire       framing_error_status;
	wire       receive_ninth_bit;
	wire       receive_data_available_flag;
	wire       shift_register_empty_status;

	////////////////////////////////////////////////////////////////////////////
	assign tx_active    = transmit_enable_bit && !mode_select_bit && port_enable_bit;
	assign rx_active    = continuous_receive_enable && !mode_select_bit && port_enable_bit;
	assign tx_write     = wr && (addr == `ADDR_TX_DATA);
	assign rx_pop       = rd && (addr == `ADDR_RX_DATA);
	assign baud_restart = wr && ((addr == `ADDR_BAUD_LOW) || (addr == `ADDR_BAUD_HIGH));

	baud_tick_gen u_baud (
		.clk       (clk),
		.rst_n     (rst_n),
		.wide_mode (baud_wide),
		.period    ({baud_high, baud_low}),
		.restart   (baud_restart),
		.tick      (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register writes.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_enable_bit       <= 1'b0;
			nine_bit_transmit_select  <= 1'b0;
			output_polarity_bit       <= 1'b0;
			transmit_ninth_bit        <= 1'b0;
			port_enable_bit           <= 1'b0;
			continuous_receive_enable <= 1'b0;
			nine_bit_receive_select   <= 1'b0;
			address_detect_enable     <= 1'b0;
			mode_select_bit           <= 1'b0;
			baud_wide                 <= 1'b0;
			baud_low                  <= `BAUD_LOW_RESET;
			baud_high                 <= `BAUD_HIGH_RESET;
		end else if (wr) begin
			if (addr == `ADDR_TX_CTRL) begin
				transmit_enable_bit      <= wdata[`TXC_ENABLE];
				nine_bit_transmit_select <= wdata[`TXC_NINE];
				output_polarity_bit      <= wdata[`TXC_POLARITY];
				transmit_ninth_bit       <= wdata[`TXC_NINTH_BIT];
			end else if (addr == `ADDR_RX_CTRL) begin
				port_enable_bit           <= wdata[`RXC_PORT_ENABLE];
				continuous_receive_enable <= wdata[`RXC_CONT_RECEIVE];
				nine_bit_receive_select   <= wdata[`RXC_NINE];
				address_detect_enable     <= wdata[`RXC_ADDR_DETECT];
				mode_select_bit           <= wdata[`RXC_MODE_SELECT];
			end else if (addr == `ADDR_BAUD_CTRL) begin
				baud_wide <= wdata[`BAUD_WIDE];
			end else if (addr == `ADDR_BAUD_LOW) begin
				baud_low <= wdata;
			end else if (addr == `ADDR_BAUD_HIGH) begin
				baud_high <= wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit buffer and shift register.
	assign tx_load = buffer_full && !tx_busy && tx_active;
	assign shift_register_empty_status = !tx_busy;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_buffer <= `BYTE_ZERO;
			buffer_ninth    <= 1'b0;
			buffer_full     <= 1'b0;
		end else if (!port_enable_bit) begin
			buffer_full <= 1'b0;
		end else if (tx_write) begin
			transmit_buffer <= wdata;
			buffer_ninth    <= transmit_ninth_bit;
			buffer_full     <= 1'b1;
		end else if (tx_load) begin
			buffer_full <= 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_shift_register <= 11'h7ff;
			tx_bits_left            <= `TICK_ZERO;
			tx_ticks                <= `TICK_ZERO;
			tx_busy                 <= 1'b0;
		end else if (!tx_active) begin
			transmit_shift_register <= 11'h7ff;
			tx_bits_left            <= `TICK_ZERO;
			tx_ticks                <= `TICK_ZERO;
			tx_busy                 <= 1'b0;
		end else if (tx_load) begin
			// Stop, optional ninth bit, data and start; LSB leaves first.
			transmit_shift_register <= {1'b1, nine_bit_transmit_select ? buffer_ninth : 1'b1,
				transmit_buffer, 1'b0};
			tx_bits_left            <= nine_bit_transmit_select ? `TX_FRAME_NINE : `TX_FRAME_EIGHT;
			tx_ticks                <= `TICK_ZERO;
			tx_busy                 <= 1'b1;
		end else if (tx_busy && tick) begin
			if (tx_ticks == `TICKS_LAST) begin
				tx_ticks                <= `TICK_ZERO;
				transmit_shift_register <= {1'b1, transmit_shift_register[10:1]};
				tx_bits_left            <= tx_bits_left - 4'h1;
				if (tx_bits_left == 4'h1) begin
					tx_busy <= 1'b0;
				end
			end else begin
				tx_ticks <= tx_ticks + 4'h1;
			end
		end
	end

	// Registered flag, so it settles one cycle after the buffer write.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_buffer_empty_flag <= 1'b0;
		end else begin
			transmit_buffer_empty_flag <= tx_active && !buffer_full;
		end
	end

	// Gated by the enables so the line drops to idle in the same cycle the port or transmitter is switched off.
	assign tx_line = ((tx_busy && tx_active) ? transmit_shift_register[0] : 1'b1)
		^ output_polarity_bit;
	assign tx_oe   = port_enable_bit;

	////////////////////////////////////////////////////////////////////////////
	// Receiver: oversampling data recovery and receive shift register.
	assign rx_vote  = majority(rx_samples);
	assign rx_char  = nine_bit_receive_select ? receive_shift_register[7:0] : receive_shift_register[8:1];
	assign rx_ninth = nine_bit_receive_select ? receive_shift_register[8] : 1'b0;
	assign rx_keep  = !(address_detect_enable && nine_bit_receive_select && !rx_ninth);
	assign rx_push  = rx_active && (rx_state == RX_STOP) && tick && (rx_ticks == `TICKS_LAST)
		&& rx_keep && !overrun_error_status && !fifo_full;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_samples <= 3'b111;
			rx_prev    <= 1'b1;
		end else begin
			rx_prev <= rx_line;
			if (tick) begin
				rx_samples <= {rx_samples[1:0], rx_line};
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state               <= RX_IDLE;
			rx_ticks               <= `TICK_ZERO;
			rx_bits                <= `TICK_ZERO;
			receive_shift_register <= 9'h000;
		end else if (!rx_active || overrun_error_status) begin
			rx_state <= RX_IDLE;
			rx_ticks <= `TICK_ZERO;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (rx_prev && !rx_line) begin
						rx_state <= RX_START;
						rx_ticks <= `TICK_ZERO;
					end
				end
				RX_START: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 4'h1;
						if (rx_ticks == `TICKS_HALF) begin
							rx_ticks <= `TICK_ZERO;
							rx_bits  <= `TICK_ZERO;
							rx_state <= rx_vote ? RX_IDLE : RX_DATA;
						end
					end
				end
				RX_DATA: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 4'h1;
						if (rx_ticks == `TICKS_LAST) begin
							receive_shift_register <= {rx_vote, receive_shift_register[8:1]};
							rx_bits                <= rx_bits + 4'h1;
							if (rx_bits == (nine_bit_receive_select ? `RX_DATA_NINE : `RX_DATA_EIGHT) - 4'h1) begin
								rx_state <= RX_STOP;
							end
						end
					end
				end
				default: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 4'h1;
						if (rx_ticks == `TICKS_LAST) begin
							rx_state <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Overrun: a kept character arrives with both entries full.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_error_status <= 1'b0;
		end else if (!continuous_receive_enable || !port_enable_bit) begin
			overrun_error_status <= 1'b0;
		end else if (rx_active && (rx_state == RX_STOP) && tick && (rx_ticks == `TICKS_LAST)
			&& rx_keep && fifo_full) begin
			overrun_error_status <= 1'b1;
		end
	end

	receive_fifo u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.flush     (!port_enable_bit),
		.push      (rx_push),
		.push_data ({~rx_vote, rx_ninth, rx_char}),
		.pop       (rx_pop),
		.head      (fifo_head),
		.empty     (fifo_empty),
		.full      (fifo_full)
	);

	assign framing_error_status        = !fifo_empty && fifo_head[`ENTRY_FRAMING_ERROR_STATUS];
	assign receive_ninth_bit           = !fifo_empty && fifo_head[`ENTRY_NINTH];
	assign receive_data_available_flag = rx_active && !fifo_empty;

	////////////////////////////////////////////////////////////////////////////
	// Register reads; data stands in the cycle after the read strobe.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `BYTE_ZERO;
		end else if (rd) begin
			if (addr == `ADDR_TX_CTRL) begin
				rdata <= {2'b00, transmit_buffer_empty_flag, shift_register_empty_status,
					transmit_ninth_bit, output_polarity_bit, nine_bit_transmit_select, transmit_enable_bit};
			end else if (addr == `ADDR_RX_CTRL) begin
				rdata <= {receive_ninth_bit, overrun_error_status, framing_error_status, mode_select_bit,
					address_detect_enable, nine_bit_receive_select, continuous_receive_enable, port_enable_bit};
			end else if (addr == `ADDR_BAUD_CTRL) begin
				rdata <= {7'h00, baud_wide};
			end else if (addr == `ADDR_BAUD_LOW) begin
				rdata <= baud_low;
			end else if (addr == `ADDR_BAUD_HIGH) begin
				rdata <= baud_high;
			end else if (addr == `ADDR_RX_DATA) begin
				rdata <= fifo_empty ? `BYTE_ZERO : fifo_head[7:0];
			end else if (addr == `ADDR_FLAGS) begin
				rdata <= {6'h00, receive_data_available_flag, transmit_buffer_empty_flag};
			end else begin
				rdata <= `BYTE_ZERO;
			end
		end
	end

endmodule // async_serial_transceiver

`default_nettype wire

// [dv/async_serial_transceiver_asserts.sv]
// Port-level checks for the asynchronous serial transceiver.
`default_nettype none
`include "serial_unit_consts.vh"

module serial_link_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       rx_line,
	input wire logic       tx_line,
	input wire logic       tx_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// Mirrors of the control bits and the length of the present true line level.
	logic       port_en, tx_en, mode_sel, pol, baud_nz, txd_q;
	logic [1:0] wr_recent;
	logic [7:0] run;
	wire        txd     = tx_line ^ pol;
	wire        tx_on   = port_en & tx_en & ~mode_sel;
	wire        tx_wr   = wr && addr == `ADDR_TX_DATA;
	wire        idle_ok = txd && run >= 8'hb0 && !baud_nz && wr_recent == 2'b00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{port_en, tx_en, mode_sel, pol, baud_nz} <= 5'h00;
			txd_q <= 1'b1;
			wr_recent <= 2'b00;
			run <= 8'h00;
		end else begin
			if (wr && addr == `ADDR_TX_CTRL) begin
				tx_en <= wdata[`TXC_ENABLE];
				pol <= wdata[`TXC_POLARITY];
			end
			if (wr && addr == `ADDR_RX_CTRL) begin
				port_en <= wdata[`RXC_PORT_ENABLE];
				mode_sel <= wdata[`RXC_MODE_SELECT];
			end
			if (wr && (addr == `ADDR_BAUD_LOW || addr == `ADDR_BAUD_HIGH) && wdata != 8'h00) begin
				baud_nz <= 1'b1;
			end
			wr_recent <= {wr_recent[0], tx_wr};
			txd_q <= txd;
			if (txd != txd_q) begin
				run <= 8'h01;
			end else if (run != 8'hff) begin
				run <= run + 8'h01;
			end
		end
	end
	chk_idle_level: assert property (!port_en |-> tx_line == !pol)
		else $error("tx line off idle level with port disabled");
	chk_oe_port: assert property (tx_oe == port_en)
		else $error("tx output enable differs from port enable");
	chk_bit_width: assert property (txd != txd_q |-> run >= 8'h0f)
		else $error("tx bit shorter than one bit time");
	chk_frame_low: assert property (!txd && !txd_q && !baud_nz |-> run <= 8'ha0)
		else $error("tx low longer than start plus nine bits");
	chk_tx_start: assert property (tx_wr && tx_on && idle_ok |-> ##[1:3] !txd)
		else $error("start bit not launched after write to idle transmitter");
	chk_flag_idle: assert property (rd && addr == `ADDR_FLAGS && tx_on && idle_ok |=> rdata[`FLAG_TX])
		else $error("transmit flag low while buffer empty");
	chk_shift_busy: assert property (rd && addr == `ADDR_TX_CTRL && !txd |=> !rdata[`TXC_SHIFT_EMPTY])
		else $error("shift empty status set while shifting");
	chk_shift_idle: assert property (rd && addr == `ADDR_TX_CTRL && idle_ok |=> rdata[`TXC_SHIFT_EMPTY])
		else $error("shift empty status clear while idle");
	cover property (tx_wr && tx_on);
	cover property (rd && addr == `ADDR_RX_DATA);
	cover property (!txd && txd_q);
endmodule // serial_link_checker

bind async_serial_transceiver serial_link_checker u_link_checker (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line), .tx_oe(tx_oe));
`default_nettype wire

// [dv/serial_peer.sv]
// Behavioural remote transceiver on the serial lines.
`default_nettype none

module serial_peer (
	input  wire logic clk,
	input  wire logic line_in,
	input  wire logic inverted,
	input  wire logic nine,
	output var  logic line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int bit_clks = 16;
	logic [9:0] got[$];
	time        starts[$];
	logic [8:0] shift;
	// Receiver: rechecks the start at half a bit, then samples each bit centre.
	initial begin
		line_out = 1'b1;
		forever begin
			@(posedge clk);
			if (line_in ^ inverted) continue;
			repeat (bit_clks / 2) @(posedge clk);
			if (line_in ^ inverted) continue;
			starts.push_back($time);
			shift = 9'h000;
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (bit_clks) @(posedge clk);
				shift[i] = line_in ^ inverted;
			end
			repeat (bit_clks) @(posedge clk);
			got.push_back({line_in ^ inverted, shift});
		end
	end
	// Sends one frame and then rests at the mark level for a bit time.
	task automatic send(input logic [8:0] d, input logic n9, input logic stop);
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (int i = 0; i < (n9 ? 9 : 8); i++) begin
			line_out <= d[i];
			repeat (bit_clks) @(posedge clk);
		end
		line_out <= stop;
		repeat (bit_clks) @(posedge clk);
		line_out <= 1'b1;
		repeat (bit_clks) @(posedge clk);
	endtask
	task automatic glitch();
		line_out <= 1'b0;
		repeat (bit_clks / 4) @(posedge clk);
		line_out <= 1'b1;
		repeat (2 * bit_clks) @(posedge clk);
	endtask
endmodule // serial_peer
`default_nettype wire

// [dv/async_serial_transceiver_tb.sv]
// Self-checking bench for the asynchronous serial transceiver.
`default_nettype none
`include "serial_unit_consts.vh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module async_serial_transceiver_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic pol; logic nine; logic [8:0] d; logic stop;} row_t;
	logic       clk, rst_n, wr, rd, rx_line, tx_line, tx_oe, inv, peer_nine;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v;
	logic [9:0] g;
	int         n_mismatch = 0;
	int         n_compared = 0;
	time        gap;
	row_t       r;
	row_t       rows [5] = '{'{1'b0, 1'b0, 9'h055, 1'b1}, '{1'b1, 1'b0, 9'h0c3, 1'b1},
		'{1'b0, 1'b1, 9'h1a6, 1'b1}, '{1'b1, 1'b1, 9'h081, 1'b0}, '{1'b0, 1'b0, 9'h000, 1'b0}};

	async_serial_transceiver dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rx_line(rx_line), .tx_line(tx_line), .tx_oe(tx_oe));
	serial_peer peer (.clk(clk), .line_in(tx_line), .inverted(inv), .nine(peer_nine), .line_out(rx_line));

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// Read data stand from the cycle after the strobe, so they are taken mid-cycle.
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
		`CHK(v, exp)
		@(posedge clk);
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, wr, rd, inv, peer_nine} = 5'h00;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (2) @(posedge clk);
		`CHK(tx_line, 1'b1)
		`CHK(tx_oe, 1'b0)
		rst_n <= 1'b1;
		@(posedge clk);
		chk_rd(`ADDR_TX_CTRL, 8'h10);
		chk_rd(`ADDR_FLAGS, 8'h00);
		chk_rd(4'hc, 8'h00);
		foreach (rows[i]) begin
			r = rows[i];
			wr_reg(`ADDR_TX_CTRL, {4'h0, r.d[8], r.pol, r.nine, 1'b1});
			inv <= r.pol;
			wr_reg(`ADDR_RX_CTRL, {5'h00, r.nine, 2'h3});
			peer_nine <= r.nine;
			wait_clk(16);
			wr_reg(`ADDR_TX_DATA, r.d[7:0]);
			wait_clk(200);
			`CHK(peer.got.size(), 1)
			g = (peer.got.size() > 0) ? peer.got.pop_front() : 'x;
			`CHK(g, {1'b1, r.nine & r.d[8], r.d[7:0]})
			peer.send(r.d, r.nine, r.stop);
			chk_rd(`ADDR_RX_CTRL, {r.nine & r.d[8], 1'b0, ~r.stop, 2'b00, r.nine, 2'b11});
			chk_rd(`ADDR_FLAGS, 8'h03);
			chk_rd(`ADDR_RX_DATA, r.d[7:0]);
		end
		peer.starts.delete();
		wr_reg(`ADDR_TX_DATA, 8'ha5);
		wr_reg(`ADDR_TX_DATA, 8'h3c);
		chk_rd(`ADDR_FLAGS, 8'h00);
		chk_rd(`ADDR_TX_CTRL, 8'h01);
		wait_clk(360);
		`CHK(peer.got.size(), 2)
		gap = (peer.starts.size() == 2) ? peer.starts[1] - peer.starts[0] : 0;
		`CHK(gap >= 1280 && gap <= 1296, 1'b1)
		g = (peer.got.size() > 0) ? peer.got.pop_front() : 'x;
		`CHK(g, 10'h2a5)
		g = (peer.got.size() > 0) ? peer.got.pop_front() : 'x;
		`CHK(g, 10'h23c)
		chk_rd(`ADDR_TX_CTRL, 8'h31);
		peer.glitch();
		chk_rd(`ADDR_RX_CTRL, 8'h03);
		chk_rd(`ADDR_FLAGS, 8'h01);
		peer.send(9'h011, 1'b0, 1'b0);
		peer.send(9'h022, 1'b0, 1'b1);
		peer.send(9'h033, 1'b0, 1'b1);
		chk_rd(`ADDR_RX_CTRL, 8'h63);
		peer.send(9'h044, 1'b0, 1'b1);
		wr_reg(`ADDR_RX_CTRL, 8'h01);
		chk_rd(`ADDR_RX_CTRL, 8'h21);
		chk_rd(`ADDR_FLAGS, 8'h01);
		wr_reg(`ADDR_RX_CTRL, 8'h03);
		chk_rd(`ADDR_RX_DATA, 8'h11);
		chk_rd(`ADDR_RX_CTRL, 8'h03);
		chk_rd(`ADDR_RX_DATA, 8'h22);
		chk_rd(`ADDR_FLAGS, 8'h01);
		peer.send(9'h055, 1'b0, 1'b0);
		chk_rd(`ADDR_RX_CTRL, 8'h23);
		wr_reg(`ADDR_RX_CTRL, 8'h00);
		chk_rd(`ADDR_RX_CTRL, 8'h00);
		wr_reg(`ADDR_RX_CTRL, 8'h0f);
		peer.send(9'h0aa, 1'b1, 1'b1);
		peer.send(9'h1bb, 1'b1, 1'b1);
		chk_rd(`ADDR_RX_CTRL, 8'h8f);
		chk_rd(`ADDR_RX_DATA, 8'hbb);
		chk_rd(`ADDR_FLAGS, 8'h01);
		wr_reg(`ADDR_RX_CTRL, 8'h13);
		wr_reg(`ADDR_TX_DATA, 8'h77);
		peer.send(9'h066, 1'b0, 1'b1);
		`CHK(peer.got.size(), 0)
		wr_reg(`ADDR_RX_CTRL, 8'h03);
		chk_rd(`ADDR_RX_DATA, 8'h00);
		chk_rd(`ADDR_RX_CTRL, 8'h03);
		// Reset again in mid-run, while the held character is on the line.
		rst_n <= 1'b0;
		wait_clk(2);
		`CHK(tx_line, 1'b1)
		`CHK(tx_oe, 1'b0)
		rst_n <= 1'b1;
		@(posedge clk);
		chk_rd(`ADDR_RX_CTRL, 8'h00);
		wr_reg(`ADDR_BAUD_CTRL, 8'h01);
		wr_reg(`ADDR_BAUD_HIGH, 8'h12);
		chk_rd(`ADDR_BAUD_CTRL, 8'h01);
		chk_rd(`ADDR_BAUD_HIGH, 8'h12);
		finish_test();
	end
endmodule // async_serial_transceiver_tb
`default_nettype wire
